// file: rtl/trl_pkg.sv
/*
 Shared constants for the temperature result, limit and status register block:
 pointer offsets, reset values, status bit positions.
 Assumes an 8-bit register bus driven by an external serial front end.
*/
package trl_pkg;
	// ==========================================================
	// Read pointers
	localparam logic [7:0] RD_LOCAL_TEMP_MSB      = 8'h00;
	localparam logic [7:0] RD_REMOTE_TEMP_MSB     = 8'h01;
	localparam logic [7:0] RD_COMPARATOR_FLAGS    = 8'h02;
	localparam logic [7:0] RD_LOCAL_UPPER_MSB     = 8'h05;
	localparam logic [7:0] RD_LOCAL_LOWER_MSB     = 8'h06;
	localparam logic [7:0] RD_REMOTE_UPPER_MSB    = 8'h07;
	localparam logic [7:0] RD_REMOTE_LOWER_MSB    = 8'h08;
	// ==========================================================
	// Write pointers
	localparam logic [7:0] WR_LOCAL_UPPER_MSB     = 8'h0b;
	localparam logic [7:0] WR_LOCAL_LOWER_MSB     = 8'h0c;
	localparam logic [7:0] WR_REMOTE_UPPER_MSB    = 8'h0d;
	localparam logic [7:0] WR_REMOTE_LOWER_MSB    = 8'h0e;
	// ==========================================================
	// Shared read/write pointers; the temperature low bytes are read only
	localparam logic [7:0] REMOTE_TEMP_LSB        = 8'h10;
	localparam logic [7:0] REMOTE_UPPER_LSB       = 8'h13;
	localparam logic [7:0] REMOTE_LOWER_LSB       = 8'h14;
	localparam logic [7:0] LOCAL_TEMP_LSB         = 8'h15;
	localparam logic [7:0] LOCAL_UPPER_LSB        = 8'h16;
	localparam logic [7:0] LOCAL_LOWER_LSB        = 8'h17;
	localparam logic [7:0] REMOTE_OVERTEMP_BOUND  = 8'h19;
	localparam logic [7:0] LOCAL_OVERTEMP_BOUND   = 8'h20;
	localparam logic [7:0] OVERTEMP_HYSTERESIS    = 8'h21;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_ZERO               = 8'h00;
	localparam logic [7:0] RST_UPPER_MSB          = 8'h55;
	localparam logic [7:0] RST_OVERTEMP           = 8'h55;
	localparam logic [7:0] RST_HYSTERESIS         = 8'h0a;
	localparam logic [7:0] RST_POINTER            = 8'h00;
	// ==========================================================
	// Status bit positions
	localparam int         ST_BUSY                = 7;
	localparam int         ST_LOCAL_UPPER         = 6;
	localparam int         ST_LOCAL_LOWER         = 5;
	localparam int         ST_REMOTE_UPPER        = 4;
	localparam int         ST_REMOTE_LOWER        = 3;
	localparam int         ST_OPEN                = 2;
	localparam int         ST_REMOTE_OVERTEMP     = 1;
	localparam int         ST_LOCAL_OVERTEMP      = 0;
	// Channel index into per-channel arrays
	localparam int         CH_LOCAL               = 0;
	localparam int         CH_REMOTE              = 1;
endpackage

// file: rtl/trl_channel_cmp.sv
/*
 One channel's comparators: upper, lower and overtemperature against a
 new 12-bit result. Evaluated once per completed conversion.
 Assumes limits use the same left-justified 12-bit format as results.
*/
`timescale 1ns/1ps
`default_nettype none
module trl_channel_cmp
	import trl_pkg::*;
(
	// Result and limits
	input  wire logic [11:0] result,
	input  wire logic [11:0] upper_bound,
	input  wire logic [11:0] lower_bound,
	input  wire logic [7:0]  overtemp_bound,
	input  wire logic [7:0]  hysteresis,
	// Previous live flags for hysteresis
	input  wire logic        upper_live_prev,
	input  wire logic        overtemp_prev,
	// Outcomes
	output logic             upper_exceeded,
	output logic             lower_exceeded,
	output logic             upper_live,
	output logic             overtemp
);
	logic [8:0] ot_release;
	logic [12:0] up_release;

	// Release points clamp at zero so a large hysteresis cannot wrap
	assign ot_release = ({1'b0, overtemp_bound} > {1'b0, hysteresis}) ?
		({1'b0, overtemp_bound} - {1'b0, hysteresis}) : 9'h000;
	assign up_release = ({1'b0, upper_bound} > {1'b0, hysteresis, 4'h0}) ?
		({1'b0, upper_bound} - {1'b0, hysteresis, 4'h0}) : 13'h0000;

	assign upper_exceeded = result > upper_bound;
	assign lower_exceeded = result < lower_bound;
	assign upper_live     = upper_exceeded |
		(upper_live_prev & ({1'b0, result} > up_release));
	assign overtemp       = (result[11:4] > overtemp_bound) |
		(overtemp_prev & ({1'b0, result[11:4]} > ot_release));
endmodule
`default_nettype wire

// file: rtl/trl_regs.sv
/*
 Result, limit and status register file of a two-channel temperature
 monitor, reached through an 8-bit pointer from a serial front end.
 Assumes the front end gives one-cycle strobes: pointer load, data write,
 data read; rd_data is valid the cycle after a read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module trl_regs
	import trl_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Register port from serial front end
	input  wire logic        ptr_wr,
	input  wire logic [7:0]  ptr_data,
	input  wire logic        data_wr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        data_rd,
	output logic [7:0]       rd_data,
	// Alert response address read done by the front end
	input  wire logic        alert_ack,
	// Converter side
	input  wire logic        conv_busy,
	input  wire logic        conv_done,
	input  wire logic        conv_remote,
	input  wire logic [11:0] conv_result,
	input  wire logic        diode_open,
	// Mode bit held in the configuration register elsewhere
	input  wire logic        pin_function_select,
	// Pins
	output logic             fault_irq_pin_n,
	output logic             overtemp_output_n
);
	// ==========================================================
	// Storage
	logic [7:0]  pointer;
	logic [11:0] temp      [2];
	logic [3:0]  temp_lsb_snap [2];
	logic [11:0] upper     [2];
	logic [11:0] lower     [2];
	logic [7:0]  ot_bound  [2];
	logic [7:0]  hysteresis;
	logic        upper_flag  [2];
	logic        lower_flag  [2];
	logic        ot_flag     [2];
	logic        open_flag;
	logic        busy_flag;
	logic        upper_hit_last [2];
	logic        lower_hit_last [2];
	logic        open_last;
	logic        upper_hit [2];
	logic        lower_hit [2];
	logic        upper_lv  [2];
	logic        ot_lv     [2];
	logic        open_seen;
	logic [5:0]  alert_src;
	logic [5:0]  alert_src_d;
	logic        status_rd;
	logic [7:0]  status;
	logic [7:0]  next_rd_data;

	// Pointer match, shared by the status and snapshot decodes
	function automatic logic ptr_hits(input logic [7:0] ptr, input logic [7:0] off);
		ptr_hits = (ptr == off);
	endfunction

	// ==========================================================
	// Pointer
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pointer <= RST_POINTER;
		end else if (ptr_wr) begin
			pointer <= ptr_data;
		end else if (data_wr || data_rd) begin
			// Auto-advance only within a high/low pair for two-byte transfers
			unique case (pointer)
				RD_LOCAL_TEMP_MSB:   pointer <= LOCAL_TEMP_LSB;
				RD_REMOTE_TEMP_MSB:  pointer <= REMOTE_TEMP_LSB;
				RD_LOCAL_UPPER_MSB,
				WR_LOCAL_UPPER_MSB:  pointer <= LOCAL_UPPER_LSB;
				RD_LOCAL_LOWER_MSB,
				WR_LOCAL_LOWER_MSB:  pointer <= LOCAL_LOWER_LSB;
				RD_REMOTE_UPPER_MSB,
				WR_REMOTE_UPPER_MSB: pointer <= REMOTE_UPPER_LSB;
				RD_REMOTE_LOWER_MSB,
				WR_REMOTE_LOWER_MSB: pointer <= REMOTE_LOWER_LSB;
				default:             pointer <= pointer;
			endcase
		end
	end

	// ==========================================================
	// Comparators, one per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_cmp
			trl_channel_cmp u_cmp (
				.result          (conv_result),
				.upper_bound     (upper[ch]),
				.lower_bound     (lower[ch]),
				.overtemp_bound  (ot_bound[ch]),
				.hysteresis      (hysteresis),
				.upper_live_prev (upper_flag[ch]),
				.overtemp_prev   (ot_flag[ch]),
				.upper_exceeded  (upper_hit[ch]),
				.lower_exceeded  (lower_hit[ch]),
				.upper_live      (upper_lv[ch]),
				.overtemp        (ot_lv[ch])
			);
		end
	endgenerate

	// ==========================================================
	// Results and low-byte snapshot
	generate
		for (ch = 0; ch < 2; ch++) begin : g_res
			logic is_ch;
			logic [7:0] msb_ptr;
			assign is_ch   = (conv_remote == (ch == CH_REMOTE));
			assign msb_ptr = (ch == CH_REMOTE) ? RD_REMOTE_TEMP_MSB : RD_LOCAL_TEMP_MSB;
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					temp[ch] <= {RST_ZERO, RST_ZERO[3:0]};
				end else if (conv_done && is_ch) begin
					temp[ch] <= conv_result;
				end
			end
			// Low nibble frozen when its high byte is read
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					temp_lsb_snap[ch] <= RST_ZERO[3:0];
				end else if (data_rd && ptr_hits(pointer, msb_ptr)) begin
					temp_lsb_snap[ch] <= (conv_done && is_ch) ?
						conv_result[3:0] : temp[ch][3:0];
				end
			end
		end
	endgenerate

	// Coherence window: open after a high byte read, closed by any other read
	logic coherent [2];
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			coherent[CH_LOCAL]  <= 1'b0;
			coherent[CH_REMOTE] <= 1'b0;
		end else if (data_rd) begin
			coherent[CH_LOCAL]  <= (pointer == RD_LOCAL_TEMP_MSB);
			coherent[CH_REMOTE] <= (pointer == RD_REMOTE_TEMP_MSB);
		end
	end

	// ==========================================================
	// Limit writes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			upper[CH_LOCAL]     <= {RST_UPPER_MSB, RST_ZERO[3:0]};
			lower[CH_LOCAL]     <= {RST_ZERO, RST_ZERO[3:0]};
			upper[CH_REMOTE]    <= {RST_UPPER_MSB, RST_ZERO[3:0]};
			lower[CH_REMOTE]    <= {RST_ZERO, RST_ZERO[3:0]};
			ot_bound[CH_LOCAL]  <= RST_OVERTEMP;
			ot_bound[CH_REMOTE] <= RST_OVERTEMP;
			hysteresis          <= RST_HYSTERESIS;
		end else if (data_wr) begin
			unique case (pointer)
				WR_LOCAL_UPPER_MSB:    upper[CH_LOCAL][11:4]  <= wr_data;
				LOCAL_UPPER_LSB:       upper[CH_LOCAL][3:0]   <= wr_data[7:4];
				WR_LOCAL_LOWER_MSB:    lower[CH_LOCAL][11:4]  <= wr_data;
				LOCAL_LOWER_LSB:       lower[CH_LOCAL][3:0]   <= wr_data[7:4];
				WR_REMOTE_UPPER_MSB:   upper[CH_REMOTE][11:4] <= wr_data;
				REMOTE_UPPER_LSB:      upper[CH_REMOTE][3:0]  <= wr_data[7:4];
				WR_REMOTE_LOWER_MSB:   lower[CH_REMOTE][11:4] <= wr_data;
				REMOTE_LOWER_LSB:      lower[CH_REMOTE][3:0]  <= wr_data[7:4];
				LOCAL_OVERTEMP_BOUND:  ot_bound[CH_LOCAL]     <= wr_data;
				REMOTE_OVERTEMP_BOUND: ot_bound[CH_REMOTE]    <= wr_data;
				OVERTEMP_HYSTERESIS:   hysteresis             <= wr_data;
				// Status and results ignore writes
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Status flags
	assign status_rd = data_rd && ptr_hits(pointer, RD_COMPARATOR_FLAGS);
	assign open_seen = conv_done && conv_remote && diode_open;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_flag <= 1'b0;
		end else begin
			busy_flag <= conv_busy;
		end
	end

	generate
		for (ch = 0; ch < 2; ch++) begin : g_flag
			logic ev;
			assign ev = conv_done && (conv_remote == (ch == CH_REMOTE));
			// Set wins over a clearing read in the same cycle
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					upper_flag[ch] <= 1'b0;
				end else if (pin_function_select) begin
					if (ev) begin
						upper_flag[ch] <= upper_lv[ch];
					end
				end else if (ev && upper_hit[ch]) begin
					upper_flag[ch] <= 1'b1;
				end else if (status_rd && !upper_hit_last[ch]) begin
					upper_flag[ch] <= 1'b0;
				end
			end
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					lower_flag[ch] <= 1'b0;
				end else if (ev && lower_hit[ch]) begin
					lower_flag[ch] <= 1'b1;
				end else if (status_rd && !lower_hit_last[ch]) begin
					lower_flag[ch] <= 1'b0;
				end
			end
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					ot_flag[ch] <= 1'b0;
				end else if (ev) begin
					ot_flag[ch] <= ot_lv[ch];
				end
			end
			// Cause as seen at the last conversion of this channel
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					upper_hit_last[ch] <= 1'b0;
					lower_hit_last[ch] <= 1'b0;
				end else if (ev) begin
					upper_hit_last[ch] <= upper_hit[ch];
					lower_hit_last[ch] <= lower_hit[ch];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			open_flag <= 1'b0;
			open_last <= 1'b0;
		end else begin
			if (conv_done && conv_remote) begin
				open_last <= diode_open;
			end
			if (open_seen) begin
				open_flag <= 1'b1;
			end else if (status_rd && !open_last) begin
				open_flag <= 1'b0;
			end
		end
	end

	always_comb begin
		status = 8'h00;
		status[ST_BUSY]            = busy_flag;
		status[ST_LOCAL_UPPER]     = upper_flag[CH_LOCAL];
		status[ST_LOCAL_LOWER]     = lower_flag[CH_LOCAL];
		status[ST_REMOTE_UPPER]    = upper_flag[CH_REMOTE];
		status[ST_REMOTE_LOWER]    = lower_flag[CH_REMOTE];
		status[ST_OPEN]            = open_flag;
		status[ST_REMOTE_OVERTEMP] = ot_flag[CH_REMOTE];
		status[ST_LOCAL_OVERTEMP]  = ot_flag[CH_LOCAL];
	end

	// ==========================================================
	// Read mux
	always_comb begin
		next_rd_data = 8'h00;
		unique case (pointer)
			RD_LOCAL_TEMP_MSB:     next_rd_data = temp[CH_LOCAL][11:4];
			RD_REMOTE_TEMP_MSB:    next_rd_data = temp[CH_REMOTE][11:4];
			RD_COMPARATOR_FLAGS:   next_rd_data = status;
			RD_LOCAL_UPPER_MSB:    next_rd_data = upper[CH_LOCAL][11:4];
			RD_LOCAL_LOWER_MSB:    next_rd_data = lower[CH_LOCAL][11:4];
			RD_REMOTE_UPPER_MSB:   next_rd_data = upper[CH_REMOTE][11:4];
			RD_REMOTE_LOWER_MSB:   next_rd_data = lower[CH_REMOTE][11:4];
			LOCAL_TEMP_LSB:        next_rd_data = {coherent[CH_LOCAL] ?
				temp_lsb_snap[CH_LOCAL] : temp[CH_LOCAL][3:0], 4'h0};
			REMOTE_TEMP_LSB:       next_rd_data = {coherent[CH_REMOTE] ?
				temp_lsb_snap[CH_REMOTE] : temp[CH_REMOTE][3:0], 4'h0};
			LOCAL_UPPER_LSB:       next_rd_data = {upper[CH_LOCAL][3:0], 4'h0};
			LOCAL_LOWER_LSB:       next_rd_data = {lower[CH_LOCAL][3:0], 4'h0};
			REMOTE_UPPER_LSB:      next_rd_data = {upper[CH_REMOTE][3:0], 4'h0};
			REMOTE_LOWER_LSB:      next_rd_data = {lower[CH_REMOTE][3:0], 4'h0};
			LOCAL_OVERTEMP_BOUND:  next_rd_data = ot_bound[CH_LOCAL];
			REMOTE_OVERTEMP_BOUND: next_rd_data = ot_bound[CH_REMOTE];
			OVERTEMP_HYSTERESIS:   next_rd_data = hysteresis;
			default:               next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else if (data_rd) begin
			rd_data <= next_rd_data;
		end
	end

	// ==========================================================
	// Pins
	assign alert_src = {upper_flag[CH_LOCAL], lower_flag[CH_LOCAL], upper_flag[CH_REMOTE],
		lower_flag[CH_REMOTE], open_flag, 1'b0};

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			alert_src_d <= 6'h00;
		end else begin
			alert_src_d <= alert_src;
		end
	end

	// With pin_function_select low, alert holds low until the response read, even after flags clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_irq_pin_n <= 1'b1;
		end else if (pin_function_select) begin
			fault_irq_pin_n <= ~(upper_flag[CH_LOCAL] | upper_flag[CH_REMOTE]);
		end else if (|(alert_src & ~alert_src_d)) begin
			fault_irq_pin_n <= 1'b0;
		end else if (alert_ack) begin
			fault_irq_pin_n <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			overtemp_output_n <= 1'b1;
		end else begin
			overtemp_output_n <= ~(ot_flag[CH_LOCAL] | ot_flag[CH_REMOTE]);
		end
	end
endmodule
`default_nettype wire

// file: verif/trl_regs_props.sv
/*
 Port checker for the temperature result, limit and status register block.
 Assumes it is bound to trl_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module trl_regs_props
	import trl_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic        ptr_wr,
	input  wire logic [7:0]  ptr_data,
	input  wire logic        data_wr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        data_rd,
	input  wire logic [7:0]  rd_data,
	input  wire logic        alert_ack,
	// Converter, mode and pins
	input  wire logic        conv_busy,
	input  wire logic        conv_done,
	input  wire logic        conv_remote,
	input  wire logic [11:0] conv_result,
	input  wire logic        diode_open,
	input  wire logic        pin_function_select,
	input  wire logic        fault_irq_pin_n,
	input  wire logic        overtemp_output_n
);
	// ======
	// Helper state
	logic       ptr_fresh;
	logic [7:0] ptr_val;
	logic       seen_done;
	logic [2:0] done_hist;
	logic       mapped;

	// Pointer known only right after a load or reset; auto-advance not modelled
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_fresh <= 1'b1;
			ptr_val   <= 8'h00;
		end else if (ptr_wr) begin
			ptr_fresh <= 1'b1;
			ptr_val   <= ptr_data;
		end else if (data_rd || data_wr) begin
			ptr_fresh <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seen_done <= 1'b0;
			done_hist <= 3'h0;
		end else begin
			seen_done <= seen_done | conv_done;
			done_hist <= {done_hist[1:0], conv_done};
		end
	end

	assign mapped = ptr_val inside {8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10,
		8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h20, 8'h21};

	// ======
	// Assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_rd_hold: assert property (!data_rd |=> $stable(rd_data))
		else $error("rd_data changed without a read");
	a_alert_hold: assert property (!pin_function_select && !fault_irq_pin_n && !alert_ack
		##1 !pin_function_select |-> !fault_irq_pin_n)
		else $error("fault pin released without alert response");
	a_alert_release: assert property (!pin_function_select && alert_ack && !conv_done
		&& done_hist == 3'h0 ##1 !pin_function_select |-> fault_irq_pin_n)
		else $error("fault pin not released by alert response");
	a_fault_cause: assert property ($fell(fault_irq_pin_n) && !pin_function_select
		&& !$past(pin_function_select) |-> |done_hist)
		else $error("fault pin fell with no conversion");
	a_ovt_cause: assert property ($changed(overtemp_output_n) |-> |done_hist)
		else $error("overtemp pin moved with no conversion");
	a_unmapped_zero: assert property (data_rd && !ptr_wr && ptr_fresh && !mapped
		|=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_busy_bit: assert property (data_rd && !ptr_wr && ptr_fresh && !$past(sys_rst)
		&& ptr_val == RD_COMPARATOR_FLAGS && conv_busy == $past(conv_busy)
		|=> rd_data[ST_BUSY] == $past(conv_busy))
		else $error("busy bit does not follow converter");
	a_result_zero: assert property (data_rd && !ptr_wr && ptr_fresh && !seen_done
		&& ptr_val inside {8'h00, 8'h01, 8'h10, 8'h15} |=> rd_data == 8'h00)
		else $error("result nonzero before first conversion");

	c_alert_ack: cover property (!fault_irq_pin_n && alert_ack);
	c_ovt_low: cover property ($fell(overtemp_output_n));
	c_status_rd: cover property (data_rd && ptr_fresh && ptr_val == RD_COMPARATOR_FLAGS);
endmodule
`default_nettype wire

// file: verif/trl_host.sv
/*
 Host model: issues pointer, write, read and alert response strobes.
 Assumes one-cycle strobes sampled on rising ref_clk, read data next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module trl_host (
	// Clock
	input  wire logic       ref_clk,
	// Strobes toward the device
	output logic            ptr_wr,
	output logic [7:0]      ptr_data,
	output logic            data_wr,
	output logic [7:0]      wr_data,
	output logic            data_rd,
	output logic            alert_ack,
	// Answer
	input  wire logic [7:0] rd_data
);
	// Idle cycles before each pointer, write and read strobe; raised to model a slow host
	int unsigned idle = 0;

	initial begin
		ptr_wr    = 1'b0;
		ptr_data  = 8'h00;
		data_wr   = 1'b0;
		wr_data   = 8'h00;
		data_rd   = 1'b0;
		alert_ack = 1'b0;
	end

	// Released data lines show the inverse, never a stale copy
	task automatic set_ptr(input logic [7:0] p);
		repeat (idle) @(posedge ref_clk);
		@(posedge ref_clk);
		ptr_wr   <= 1'b1;
		ptr_data <= p;
		@(posedge ref_clk);
		ptr_wr   <= 1'b0;
		ptr_data <= ~p;
	endtask

	task automatic wr(input logic [7:0] d);
		repeat (idle) @(posedge ref_clk);
		@(posedge ref_clk);
		data_wr <= 1'b1;
		wr_data <= d;
		@(posedge ref_clk);
		data_wr <= 1'b0;
		wr_data <= ~d;
	endtask

	task automatic rd(output logic [7:0] d);
		repeat (idle) @(posedge ref_clk);
		@(posedge ref_clk);
		data_rd <= 1'b1;
		@(posedge ref_clk);
		data_rd <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic ack;
		@(posedge ref_clk);
		alert_ack <= 1'b1;
		@(posedge ref_clk);
		alert_ack <= 1'b0;
		#1;
	endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
/*
 Self-checking bench for trl_regs: register map, results, flags and pins.
 Assumes trl_host drives the register port; the bench drives the converter.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import trl_pkg::*;
	// ======
	// Signals
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ptr_wr, data_wr, data_rd, alert_ack;
	logic [7:0]  ptr_data, wr_data, rd_data;
	logic        conv_busy = 1'b0;
	logic        conv_done = 1'b0;
	logic        conv_remote = 1'b0;
	logic [11:0] conv_result = 12'h000;
	logic        diode_open = 1'b0;
	logic        pin_function_select = 1'b0;
	logic        fault_irq_pin_n, overtemp_output_n;
	int          num_errors = 0;
	int          cmp_count = 0;
	localparam logic [15:0] RST_TAB [16] = '{16'h0000, 16'h0100, 16'h0200, 16'h0555,
		16'h0600, 16'h0755, 16'h0800, 16'h1000, 16'h1300, 16'h1400, 16'h1500, 16'h1600,
		16'h1700, 16'h1955, 16'h2055, 16'h210a};
	// Write pointer, read pointer, high byte, low byte
	localparam logic [31:0] LIM_TAB [4] = '{32'h0b056080, 32'h0c061040, 32'h0d077000,
		32'h0e082000};

	always #20 ref_clk = ~ref_clk;

	trl_host u_host (.ref_clk(ref_clk), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
		.data_wr(data_wr), .wr_data(wr_data), .data_rd(data_rd), .alert_ack(alert_ack),
		.rd_data(rd_data));

	trl_regs u_trl_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .ptr_wr(ptr_wr),
		.ptr_data(ptr_data), .data_wr(data_wr), .wr_data(wr_data), .data_rd(data_rd),
		.rd_data(rd_data), .alert_ack(alert_ack), .conv_busy(conv_busy),
		.conv_done(conv_done), .conv_remote(conv_remote), .conv_result(conv_result),
		.diode_open(diode_open), .pin_function_select(pin_function_select),
		.fault_irq_pin_n(fault_irq_pin_n), .overtemp_output_n(overtemp_output_n));

	// ======
	// Tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			num_errors++;
		end
	endtask

	task automatic rdn(input logic [7:0] e);
		logic [7:0] v;
		u_host.rd(v);
		chk("rd_data", e, v);
	endtask

	task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
		u_host.set_ptr(p);
		rdn(e);
	endtask

	task automatic wr1(input logic [7:0] p, input logic [7:0] d);
		u_host.set_ptr(p);
		u_host.wr(d);
	endtask

	// Flags settle one cycle after the done strobe; three cycles leave margin
	task automatic conv(input logic r, input logic [11:0] v, input logic o);
		@(posedge ref_clk);
		conv_done   <= 1'b1;
		conv_remote <= r;
		conv_result <= v;
		diode_open  <= o;
		@(posedge ref_clk);
		conv_done  <= 1'b0;
		diode_open <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic final_report;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ======
	// Sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (RST_TAB[i]) rdchk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
		foreach (LIM_TAB[i]) begin
			wr1(LIM_TAB[i][31:24], LIM_TAB[i][15:8]);
			u_host.wr(LIM_TAB[i][7:0]);
			rdchk(LIM_TAB[i][23:16], LIM_TAB[i][15:8]);
			rdn(LIM_TAB[i][7:0]);
		end
		wr1(8'h20, 8'h50);
		wr1(8'h19, 8'h48);
		wr1(8'h21, 8'h05);
		rdchk(8'h20, 8'h50);
		rdchk(8'h19, 8'h48);
		rdchk(8'h21, 8'h05);
		wr1(8'h00, 8'h12);
		wr1(8'h02, 8'hff);
		rdchk(8'h00, 8'h00);
		rdchk(8'h02, 8'h00);
		u_host.idle = 3;
		conv(1'b0, 12'h4b7, 1'b0);
		conv(1'b1, 12'h3c9, 1'b0);
		rdchk(8'h00, 8'h4b);
		rdchk(8'h15, 8'h70);
		rdchk(8'h01, 8'h3c);
		rdchk(8'h10, 8'h90);
		u_host.idle = 0;
		rdchk(8'h00, 8'h4b);
		conv(1'b0, 12'h5a3, 1'b0);
		rdn(8'h70);
		rdchk(8'h01, 8'h3c);
		conv(1'b1, 12'h3d5, 1'b0);
		rdn(8'h90);
		rdchk(8'h02, 8'h01);
		rdchk(8'h02, 8'h01);
		chk("overtemp_output_n", 8'h00, {7'h00, overtemp_output_n});
		conv(1'b0, 12'h4c0, 1'b0);
		rdchk(8'h02, 8'h01);
		conv(1'b0, 12'h4b0, 1'b0);
		rdchk(8'h02, 8'h00);
		chk("overtemp_output_n", 8'h01, {7'h00, overtemp_output_n});
		chk("fault_irq_pin_n", 8'h01, {7'h00, fault_irq_pin_n});
		conv(1'b0, 12'h090, 1'b0);
		conv(1'b0, 12'h200, 1'b0);
		rdchk(8'h02, 8'h20);
		rdchk(8'h02, 8'h00);
		chk("fault_irq_pin_n", 8'h00, {7'h00, fault_irq_pin_n});
		u_host.ack();
		chk("fault_irq_pin_n", 8'h01, {7'h00, fault_irq_pin_n});
		conv(1'b0, 12'h200, 1'b1);
		rdchk(8'h02, 8'h00);
		conv(1'b1, 12'h300, 1'b1);
		conv(1'b1, 12'h300, 1'b0);
		rdchk(8'h02, 8'h04);
		rdchk(8'h02, 8'h00);
		u_host.ack();
		wr1(8'h20, 8'h7f);
		conv(1'b0, 12'h620, 1'b0);
		conv(1'b0, 12'h200, 1'b0);
		rdchk(8'h02, 8'h40);
		rdchk(8'h02, 8'h00);
		u_host.ack();
		@(posedge ref_clk);
		pin_function_select <= 1'b1;
		conv(1'b0, 12'h620, 1'b0);
		rdchk(8'h02, 8'h40);
		chk("fault_irq_pin_n", 8'h00, {7'h00, fault_irq_pin_n});
		conv(1'b0, 12'h5c0, 1'b0);
		rdchk(8'h02, 8'h40);
		conv(1'b0, 12'h5b0, 1'b0);
		rdchk(8'h02, 8'h00);
		chk("fault_irq_pin_n", 8'h01, {7'h00, fault_irq_pin_n});
		@(posedge ref_clk);
		conv_busy <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdchk(8'h02, 8'h80);
		conv_busy <= 1'b0;
		rdchk(8'h03, 8'h00);
		final_report;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		final_report;
	end
endmodule

bind trl_regs trl_regs_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.ptr_wr(ptr_wr), .ptr_data(ptr_data), .data_wr(data_wr), .wr_data(wr_data),
	.data_rd(data_rd), .rd_data(rd_data), .alert_ack(alert_ack), .conv_busy(conv_busy),
	.conv_done(conv_done), .conv_remote(conv_remote), .conv_result(conv_result),
	.diode_open(diode_open), .pin_function_select(pin_function_select),
	.fault_irq_pin_n(fault_irq_pin_n), .overtemp_output_n(overtemp_output_n));
`default_nettype wire
